//--- dcil_interlock.sv
// dual channel interlock output gating, plausibility monitor and diagnostic shim
`include "dcil_regs.svh"
`default_nettype none
module dcil_interlock
   import dcil_pkg::*;
(
   input wire logic i_clk,             // 20 MHz system clock
   input wire logic i_rstn,            // synchronous reset, active low
   input wire logic i_safe_in_ch1,     // safety input channel 1 pin
   input wire logic i_safe_in_ch2,     // safety input channel 2 pin
   input wire logic i_diag_in,         // diagnostic input pin
   input wire logic i_actuator_ok,     // actuator detected, same clock domain
   input wire logic i_ready,           // device ready for operation
   input wire logic i_shutdown,        // safety function shutdown demand
   input wire logic i_diag_module,     // diagnostic module attached
   input wire dcil_byte_t i_serial,    // serial number to report
   input wire dcil_byte_t i_teach_left,// remaining teach-in count
   input wire dcil_byte_t i_act_name,  // current actuator short name
   output dcil_pair_s o_safe_out,      // safety outputs, registered
   output logic o_status_diag_out,     // status or diagnostic data, registered
   output logic o_unequal,             // unequal channel indication
   output logic o_locked,              // partial operation lock
   output logic o_act_refresh          // pulse requesting actuator name refresh
);
   // ------------------------------------------------------------
   // input synchronisation
   // ------------------------------------------------------------
   logic [2:0] sync_q;
   dcil_pair_s in_s;
   logic diag_s;
   dcil_sync #(.W(3)) u_sync (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_d({i_diag_in, i_safe_in_ch2, i_safe_in_ch1}),
      .o_q(sync_q)
   );
   assign in_s.ch1 = sync_q[0];
   assign in_s.ch2 = sync_q[1];
   assign diag_s = sync_q[2];

   // ------------------------------------------------------------
   // plausibility monitor
   // ------------------------------------------------------------
   dcil_plaus_e pl_r;
   dcil_plaus_e pl_nxt;
   dcil_pair_s prev_r;
   dcil_pair_s prev_nxt;
   logic fell_ch_r;
   logic fell_ch_nxt;
   logic fall1;
   logic fall2;
   logic rise1;
   logic rise2;

   always_comb begin
      pl_nxt = pl_r;
      prev_nxt = in_s;
      fell_ch_nxt = fell_ch_r;
      fall1 = prev_r.ch1 && !in_s.ch1;
      fall2 = prev_r.ch2 && !in_s.ch2;
      rise1 = !prev_r.ch1 && in_s.ch1;
      rise2 = !prev_r.ch2 && in_s.ch2;
      case (pl_r)
         DCIL_NORMAL: begin
            if (fall1 && in_s.ch2) begin
               pl_nxt = DCIL_UNEQUAL;
               fell_ch_nxt = 1'b0;
            end else if (fall2 && in_s.ch1) begin
               pl_nxt = DCIL_UNEQUAL;
               fell_ch_nxt = 1'b1;
            end
         end
         DCIL_UNEQUAL: begin
            if (!in_s.ch1 && !in_s.ch2) begin
               pl_nxt = DCIL_NORMAL;
            end else if (!fell_ch_r && rise1 && prev_r.ch2 && in_s.ch2) begin
               pl_nxt = DCIL_LOCKED;
            end else if (fell_ch_r && rise2 && prev_r.ch1 && in_s.ch1) begin
               pl_nxt = DCIL_LOCKED;
            end else if (!fell_ch_r ? !in_s.ch2 : !in_s.ch1) begin
               // the partner dropped too: no longer the unequal pattern
               pl_nxt = DCIL_NORMAL;
            end
         end
         DCIL_LOCKED: begin
            if (!in_s.ch1 && !in_s.ch2) begin
               pl_nxt = DCIL_NORMAL;
            end
         end
         default: begin
            pl_nxt = DCIL_LOCKED;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         pl_r <= DCIL_NORMAL;
         prev_r <= `DCIL_SYNC_RST;
         fell_ch_r <= 1'b0;
      end else begin
         pl_r <= pl_nxt;
         prev_r <= prev_nxt;
         fell_ch_r <= fell_ch_nxt;
      end
   end

   // ------------------------------------------------------------
   // diagnostic link shim
   // ------------------------------------------------------------
   // a simple frame: 8 request bits shifted in on diag_in, then 8 answer bits
   // shifted out on the status pin. the real link protocol lives elsewhere;
   // this only keeps the pin roles correct and the safety path untouched.
   dcil_diag_e dg_r;
   dcil_diag_e dg_nxt;
   logic [`DCIL_DIAG_CNT_W-1:0] cnt_r;
   logic [`DCIL_DIAG_CNT_W-1:0] cnt_nxt;
   dcil_byte_t sh_r;
   dcil_byte_t sh_nxt;
   logic diag_prev_r;
   logic diag_prev_nxt;
   logic refresh_r;
   logic refresh_nxt;

   function automatic dcil_byte_t dcil_answer(input dcil_byte_t req, input dcil_byte_t ser,
                                              input dcil_byte_t teach, input dcil_byte_t name);
      case (req[1:0])
         2'h1: dcil_answer = ser;
         2'h2: dcil_answer = teach;
         2'h3: dcil_answer = name;
         default: dcil_answer = {6'h00, pl_r};
      endcase
   endfunction : dcil_answer

   always_comb begin
      dg_nxt = dg_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      diag_prev_nxt = diag_s;
      refresh_nxt = 1'b0;
      if (!i_diag_module) begin
         // module absent: input ignored, link restarts from idle next time
         dg_nxt = DCIL_D_IDLE;
         cnt_nxt = '0;
      end else begin
         case (dg_r)
            DCIL_D_IDLE: begin
               if (diag_prev_r && !diag_s) begin
                  dg_nxt = DCIL_D_RECV;
                  cnt_nxt = '0;
               end
            end
            DCIL_D_RECV: begin
               sh_nxt = {sh_r[6:0], diag_s};
               cnt_nxt = cnt_r + 1'b1;
               if (cnt_r == `DCIL_DIAG_LAST) begin
                  dg_nxt = DCIL_D_SEND;
                  sh_nxt = dcil_answer({sh_r[6:0], diag_s}, i_serial, i_teach_left, i_act_name);
                  refresh_nxt = ({sh_r[0], diag_s} == 2'h3);
               end
            end
            DCIL_D_SEND: begin
               sh_nxt = {sh_r[6:0], 1'b0};
               cnt_nxt = cnt_r + 1'b1;
               if (cnt_r == `DCIL_DIAG_LAST) begin
                  dg_nxt = DCIL_D_IDLE;
               end
            end
            default: begin
               dg_nxt = DCIL_D_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         dg_r <= DCIL_D_IDLE;
         cnt_r <= '0;
         sh_r <= `DCIL_SERIAL_RST;
         diag_prev_r <= 1'b0;
         refresh_r <= 1'b0;
      end else begin
         dg_r <= dg_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         diag_prev_r <= diag_prev_nxt;
         refresh_r <= refresh_nxt;
      end
   end

   // ------------------------------------------------------------
   // output gating
   // ------------------------------------------------------------
   // the safety path reads nothing from the diagnostic shim, so a link fault
   // can never hold a channel high
   dcil_pair_s out_r;
   dcil_pair_s out_nxt;
   logic stat_r;
   logic stat_nxt;
   logic enable;

   always_comb begin
      enable = i_ready && i_actuator_ok && !i_shutdown && (pl_r != DCIL_LOCKED);
      out_nxt = `DCIL_SYNC_RST;
      if (enable) begin
         out_nxt = in_s;
      end
      if (!i_actuator_ok) begin
         out_nxt = `DCIL_SYNC_RST;
         stat_nxt = 1'b0;
      end else if (i_diag_module) begin
         stat_nxt = (dg_r == DCIL_D_SEND) ? sh_r[7] : 1'b1;
      end else begin
         stat_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         out_r <= `DCIL_SYNC_RST;
         stat_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
         stat_r <= stat_nxt;
      end
   end

   assign o_safe_out = out_r;
   assign o_status_diag_out = stat_r;
   assign o_unequal = (pl_r == DCIL_UNEQUAL);
   assign o_locked = (pl_r == DCIL_LOCKED);
   assign o_act_refresh = refresh_r;
endmodule : dcil_interlock
`default_nettype wire

//--- dcil_interlock_chk.sv
// port-level checks for the interlock output logic
`default_nettype none
module dcil_interlock_chk
   import dcil_pkg::*;
(
   input wire logic i_clk, // clock
   input wire logic i_rstn, // reset
   input wire logic i_safe_in_ch1, // pin 1
   input wire logic i_safe_in_ch2, // pin 2
   input wire logic i_actuator_ok, // actuator
   input wire logic i_ready, // ready
   input wire logic i_shutdown, // shutdown
   input wire dcil_pair_s o_safe_out, // outputs
   input wire logic o_status_diag_out, // status
   input wire logic o_unequal, // unequal
   input wire logic o_locked, // lock
   input wire logic o_act_refresh // pulse
);
   // ----
   // history guard
   // ----
   logic [2:0] up_r;
   logic [2:0] up_nxt;
   logic ok;
   logic go;
   // past values reach four edges back, so wait until none predate reset
   always_comb up_nxt = !i_rstn ? 3'h0 : (up_r == 3'h6) ? up_r : up_r + 3'h1;
   always_ff @(posedge i_clk) up_r <= up_nxt;
   assign ok = up_r == 3'h6;
   assign go = i_actuator_ok & i_ready & ~i_shutdown & ~o_locked;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   safe_follow_a: assert property (ok && $past(go) && !o_locked && !$past(o_locked, 2) |->
      o_safe_out == {$past(i_safe_in_ch1, 3), $past(i_safe_in_ch2, 3)}) else $error("outputs not following");
   absent_low_a: assert property (ok && !$past(i_actuator_ok) |->
      o_safe_out == 2'h0 && !o_status_diag_out) else $error("outputs high without actuator");
   shut_off_a: assert property (ok && ($past(i_shutdown) || !$past(i_ready)) |->
      o_safe_out == 2'h0) else $error("outputs high in shutdown");
   unequal_set_a: assert property (ok && !$past(o_unequal) && !$past(o_locked) && $past(i_safe_in_ch2, 3)
      && $past(i_safe_in_ch2, 4) && $past(i_safe_in_ch1, 4) && !$past(i_safe_in_ch1, 3) |-> o_unequal)
      else $error("unequal not flagged");
   lock_set_a: assert property (ok && $past(o_unequal) && $past(i_safe_in_ch2, 3) && $past(i_safe_in_ch2, 4)
      && !$past(i_safe_in_ch1, 4) && $past(i_safe_in_ch1, 3) |-> o_locked && !o_unequal)
      else $error("lock not raised");
   lock_hold_a: assert property (ok && $past(o_locked) && ($past(i_safe_in_ch1, 3) || $past(i_safe_in_ch2, 3))
      |-> o_locked) else $error("lock left early");
   lock_clear_a: assert property (ok && $past(o_locked) && !$past(i_safe_in_ch1, 3)
      && !$past(i_safe_in_ch2, 3) |-> !o_locked) else $error("lock not cleared");
   refresh_pulse_a: assert property (o_act_refresh |=> !o_act_refresh) else $error("refresh too long");
endmodule : dcil_interlock_chk
bind dcil_interlock dcil_interlock_chk dcil_interlock_chk_inst (.i_clk, .i_rstn, .i_safe_in_ch1, .i_safe_in_ch2,
   .i_actuator_ok, .i_ready, .i_shutdown, .o_safe_out, .o_status_diag_out, .o_unequal, .o_locked, .o_act_refresh);
`default_nettype wire

//--- dcil_partner.sv
// diagnostic module model: sends one request frame and gathers the answer
`default_nettype none
module dcil_partner
   import dcil_pkg::*;
(
   input wire logic i_clk, // clock
   input wire logic i_status, // status line
   input wire logic i_go, // start request
   input wire dcil_byte_t i_req, // request word
   output logic o_diag_in, // diag line
   output dcil_byte_t o_word, // answer
   output logic o_done // answer ready
);
   timeunit 1ns;
   timeprecision 1ns;
   // a chain serves at most 16 sensors; the model never addresses more than that
   localparam int chain_max = 16;
   int slot = 0;
   // every frame starts from idle with no setup, as after a power-up
   initial begin
      o_diag_in = 1'b1;
      o_word = 8'h00;
      o_done = 1'b0;
      forever begin
         // start request taken at the edge, well clear of the bench's own updates
         @(posedge i_clk);
         if (i_go && slot < chain_max) begin
            #2 o_diag_in = 1'b0;
            for (int k = 7; k >= 0; k--) begin
               @(posedge i_clk);
               #2 o_diag_in = i_req[k];
            end
            // line is pulled up once released
            @(posedge i_clk);
            #2 o_diag_in = 1'b1;
            repeat (2) @(posedge i_clk);
            for (int k = 7; k >= 0; k--) begin
               @(posedge i_clk);
               #1 o_word[k] = i_status;
            end
            o_done = 1'b1;
            slot++;
            @(posedge i_clk);
            #2 o_done = 1'b0;
         end
      end
   end
endmodule : dcil_partner
`default_nettype wire

//--- dcil_pkg.sv
// types of the dual channel interlock output logic
`default_nettype none
package dcil_pkg;
   typedef enum logic [1:0] {
      DCIL_NORMAL = 2'b00,
      DCIL_UNEQUAL = 2'b01,
      DCIL_LOCKED = 2'b10
   } dcil_plaus_e;
   typedef struct packed {
      logic ch1;
      logic ch2;
   } dcil_pair_s;
   typedef enum logic [1:0] {
      DCIL_D_IDLE = 2'b00,
      DCIL_D_RECV = 2'b01,
      DCIL_D_SEND = 2'b10
   } dcil_diag_e;
   typedef logic [7:0] dcil_byte_t;
endpackage : dcil_pkg
`default_nettype wire

//--- dcil_regs.svh
// constants for the dual channel interlock output logic
//
// Overview of operation
// - with actuator present and ready, each safety output follows its own safety input
// - actuator absent forces both safety outputs and the status output low
// - without diagnostic link, status output shows actuator presence only
// - one input falling while the other stays high flags unequal channels
// - that input rising again while the other stayed high locks operation partially
// - lock clears only after both inputs were low together; then rising accepted
// - diagnostic input is sampled only while a diagnostic module is attached
// - with a diagnostic module attached, status output carries diagnostic write data
// - diagnostic link re-establishes after every power-up without configuration
// - device reports serial number and remaining teach-in count over the link
// - device executes link action requests, such as returning actuator name
// - diagnostics never change the safety input to output behaviour
// - safe state or shutdown demand drives both safety outputs low
`ifndef DCIL_REGS_SVH
`define DCIL_REGS_SVH
`define DCIL_SYNC_RST 2'b00
`define DCIL_DIAG_BITS 8
`define DCIL_DIAG_CNT_W 3
`define DCIL_DIAG_LAST 3'h7
`define DCIL_SERIAL_RST 8'h00
`endif

//--- dcil_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`default_nettype none
module dcil_sync #(
   parameter int W = 3
) (
   input wire logic i_clk,          // system clock
   input wire logic i_rstn,         // synchronous reset, active low
   input wire logic [W-1:0] i_d,    // asynchronous pins
   output logic [W-1:0] o_q         // synchronised levels
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s1_nxt;
   logic [W-1:0] s2_nxt;
   always_comb begin
      s1_nxt = i_d;
      s2_nxt = s1_r;
   end
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
      end
   end
   assign o_q = s2_r;
endmodule : dcil_sync
`default_nettype wire

//--- test_dual_channel_interlock_logic.sv
// self-checking bench for the interlock output logic
`default_nettype none
module test_dual_channel_interlock_logic
   import dcil_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rstn, c1, c2, act, rdy, shut, mod, go, diag, st, unq, lck, done, refr;
   logic [7:0] pulses = 8'h00;
   logic [7:0] rq[$];
   dcil_byte_t ser, tch, nam, req, word;
   dcil_pair_s so;
   logic [4:0] vq[$];
   dcil_byte_t wq[$];
   int bad_count, comparisons, cyc;
   logic [31:0] rs = 32'h55;
   event probe;
   dcil_interlock dcil_interlock_inst (.i_clk(clk), .i_rstn(rstn), .i_safe_in_ch1(c1), .i_safe_in_ch2(c2),
      .i_diag_in(diag), .i_actuator_ok(act), .i_ready(rdy), .i_shutdown(shut), .i_diag_module(mod),
      .i_serial(ser), .i_teach_left(tch), .i_act_name(nam), .o_safe_out(so), .o_status_diag_out(st),
      .o_unequal(unq), .o_locked(lck), .o_act_refresh(refr));
   dcil_partner dcil_partner_inst (.i_clk(clk), .i_status(st), .i_go(go), .i_req(req), .o_diag_in(diag),
      .o_word(word), .o_done(done));
   // ----
   // helpers
   // ----
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction : xs
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick
   task automatic cmp_state(input logic [4:0] e, input logic [4:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: state %b not %b", $time, g, e);
      end
   endtask : cmp_state
   task automatic cmp_word(input dcil_byte_t e, input dcil_byte_t g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: word %h not %h", $time, g, e);
      end
   endtask : cmp_word
   task automatic cmp_pulse(input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: refresh count %0d not %0d", $time, g, e);
      end
   endtask : cmp_pulse
   // f is {unequal, locked}; a lock forces both outputs off
   task automatic put(input logic [1:0] p, input logic a, input logic [1:0] f);
      {c1, c2} = p;
      act = a;
      tick(4);
      vq.push_back({(a && rdy && !shut && !f[0]) ? p : 2'h0, a, f});
      -> probe;
   endtask : put
   task automatic conclude;
      if (vq.size() != 0 || wq.size() != 0 || rq.size() != 0) begin
         bad_count++;
         $display("wrong value at %0t: expected results never seen", $time);
      end
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   always @(probe) cmp_state(vq.pop_front(), {so, st, unq, lck});
   always @(posedge done) begin
      cmp_word(wq.pop_front(), word);
      cmp_pulse(rq.pop_front(), pulses);
   end
   // refresh pulses counted over the whole run; only name requests may add one
   always @(posedge clk) begin
      if (refr === 1'b1) pulses <= pulses + 8'h01;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ----
   // main sequence
   // ----
   initial begin
      {rstn, c1, c2, act, rdy, shut, mod, go, req, ser, tch, nam} = '0;
      tick(12);
      rstn = 1'b1;
      rdy = 1'b1;
      put(2'h3, 1'b1, 2'h0);
      put(2'h0, 1'b1, 2'h0);
      put(2'h2, 1'b1, 2'h0);
      put(2'h0, 1'b1, 2'h0);
      put(2'h1, 1'b1, 2'h0);
      put(2'h3, 1'b1, 2'h0);
      put(2'h3, 1'b0, 2'h0);
      shut = 1'b1;
      put(2'h3, 1'b1, 2'h0);
      shut = 1'b0;
      rdy = 1'b0;
      put(2'h3, 1'b1, 2'h0);
      rdy = 1'b1;
      put(2'h1, 1'b1, 2'h2);
      put(2'h3, 1'b1, 2'h1);
      put(2'h1, 1'b1, 2'h1);
      put(2'h3, 1'b1, 2'h1);
      put(2'h0, 1'b1, 2'h0);
      put(2'h3, 1'b1, 2'h0);
      put(2'h2, 1'b1, 2'h2);
      put(2'h0, 1'b1, 2'h0);
      put(2'h3, 1'b1, 2'h0);
      // codes 0 to 3 with random data words, then one frame with no module attached
      for (int k = 0; k < 5; k++) begin
         rs = xs(rs);
         mod = k < 4;
         {ser, tch, nam} = rs[23:0];
         req = {rs[29:24], k[1:0]};
         wq.push_back(k == 4 ? 8'hff : k == 1 ? ser : k == 2 ? tch : k == 3 ? nam : 8'h00);
         rq.push_back(k >= 3 ? 8'h01 : 8'h00);
         go = 1'b1;
         tick(1);
         go = 1'b0;
         tick(24);
         put(2'h3, 1'b1, 2'h0);
      end
      rstn = 1'b0;
      tick(3);
      vq.push_back(5'h00);
      -> probe;
      rstn = 1'b1;
      put(2'h3, 1'b1, 2'h0);
      // let the last compare run before the report
      tick(1);
      conclude();
   end
endmodule : test_dual_channel_interlock_logic
`default_nettype wire
